//--- design/scsd_pkg.sv
package scsd_pkg;
	// Clock and oscillator figures, in kHz as printed.
	localparam int CLK_KHZ = 40000;
	localparam int OSC_KHZ = 24500;
	// Register indices; the byte address is the index shifted by IDX_LSB.
	localparam int ADDR_W = 12;
	localparam int IDX_LSB = 2;
	localparam logic [7:0] IDX_SRC = 8'ha9;
	localparam logic [7:0] IDX_TRIM = 8'hb3;
	localparam logic [7:0] IDX_CTRL = 8'hb2;
	// Field positions.
	localparam int RDY_BIT = 7;
	localparam int DIV_LSB = 4;
	localparam int RSV_BIT = 3;
	localparam int SEL_LSB = 0;
	localparam int SSE_BIT = 3;
	localparam int PRE_LSB = 0;
	// Codes and reset values.
	localparam logic [2:0] SEL_INT = 3'h0;
	localparam logic [2:0] SEL_EXT = 3'h1;
	localparam logic [2:0] DIV_RST = 3'h0;
	localparam logic [1:0] PRE_D8 = 2'h0;
	localparam logic [1:0] PRE_D4 = 2'h1;
	localparam logic [1:0] PRE_D2 = 2'h2;
	localparam logic [1:0] PRE_D1 = 2'h3;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// Oscillator model: a phase accumulator whose carry is one oscillator cycle.
	localparam int PH_W = 16;
	localparam int INC_NOM = int'((longint'(OSC_KHZ) << PH_W) / CLK_KHZ);
	localparam int TRIM_MID = 64;
	localparam int TRIM_STEP = 256;
	// Spread spectrum: step size and deviation in basis points of center.
	localparam int SS_UPD = 32;
	localparam int SS_PER = 384;
	localparam int SS_STEPS = SS_PER / SS_UPD;
	localparam int SS_STEP_BP = 25;
	localparam int SS_DEV_BP = 75;
	localparam int SS_MAX = SS_DEV_BP / SS_STEP_BP;
	localparam int SS_INC = INC_NOM * SS_STEP_BP / 10000;
	localparam int DIV_MAX = 128;
	typedef enum logic [1:0] {
		SW_RUN  = 2'b01,
		SW_WAIT = 2'b10
	} scsd_sw_t;
endpackage

//--- design/scsd_div_if.sv
`timescale 1ns/1ps
interface scsd_div_if;
	logic       src_tick;
	logic [2:0] div_code;
	logic       div_write;
	logic       ready;
	logic       core_en;
	modport ctl (output src_tick, output div_code, output div_write, input ready, input core_en);
	modport div (input src_tick, input div_code, input div_write, output ready, output core_en);
endinterface

//--- design/scsd_int_osc.sv
`timescale 1ns/1ps
module scsd_int_osc
	import scsd_pkg::*;
#(
	parameter int TRIM_W = 7
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [TRIM_W-1:0] trim,
	input  wire logic              spread_enable,
	input  wire logic [1:0]        prescale,
	output logic                   pre_tick
);
	logic [PH_W-1:0] ph_reg, ph_next;
	logic [4:0]      upd_reg, upd_next;
	logic [3:0]      idx_reg, idx_next;
	logic [2:0]      pre_reg, pre_next;
	logic            osc_reg, osc_next, pre_next_t;
	logic [PH_W:0]   sum;
	int              inc;

	// Stepped triangle 0,1,2,3,2,1,0,-1,-2,-3,-2,-1 over one modulation period.
	function automatic int tri_val(input logic [3:0] i);
		if (i <= 4'(SS_MAX)) return int'(i);
		else if (i <= 4'(3 * SS_MAX)) return 2 * SS_MAX - int'(i);
		else return int'(i) - SS_STEPS;
	endfunction

	function automatic logic [2:0] pre_last(input logic [1:0] c);
		case (c)
			PRE_D8:  return 3'h7;
			PRE_D4:  return 3'h3;
			PRE_D2:  return 3'h1;
			default: return 3'h0;
		endcase
	endfunction

	// Lower trim means a larger increment, so the oscillator runs faster.
	always_comb begin
		inc = INC_NOM + (TRIM_MID - int'(trim)) * TRIM_STEP;
		if (spread_enable) inc = inc + tri_val(idx_reg) * SS_INC;
		sum = {1'b0, ph_reg} + (PH_W+1)'(inc);
		ph_next = sum[PH_W-1:0];
		osc_next = sum[PH_W];
		upd_next = upd_reg;
		idx_next = idx_reg;
		if (!spread_enable) begin
			upd_next = 5'h00;
			idx_next = 4'h0;
		end else if (osc_reg) begin
			upd_next = upd_reg + 5'h01;
			if (upd_reg == 5'(SS_UPD - 1)) begin
				idx_next = (idx_reg == 4'(SS_STEPS - 1)) ? 4'h0 : idx_reg + 4'h1;
			end
		end
		pre_next = pre_reg;
		pre_next_t = 1'b0;
		if (osc_reg) begin
			pre_next = (pre_reg >= pre_last(prescale)) ? 3'h0 : pre_reg + 3'h1;
			pre_next_t = (pre_reg >= pre_last(prescale));
		end
	end

	// Oscillator state registers.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ph_reg <= '0;
			upd_reg <= 5'h00;
			idx_reg <= 4'h0;
			pre_reg <= 3'h0;
			osc_reg <= 1'b0;
			pre_tick <= 1'b0;
		end else begin
			ph_reg <= ph_next;
			upd_reg <= upd_next;
			idx_reg <= idx_next;
			pre_reg <= pre_next;
			osc_reg <= osc_next;
			pre_tick <= pre_next_t;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_ss_step_rate: assert property ($changed(idx_reg) && spread_enable |->
		$past(upd_reg) == 5'(SS_UPD - 1) && $past(osc_reg))
		else $error("Spread step moved off a 32 cycle boundary.");
	a_ss_off_flat: assert property (!spread_enable |=> idx_reg == 4'h0)
		else $error("Spread modulation active while disabled.");
endmodule

//--- design/scsd_sysdiv.sv
`timescale 1ns/1ps
module scsd_sysdiv
	import scsd_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	scsd_div_if.div   dv
);
	logic [6:0] cnt_reg, cnt_next;
	logic [2:0] act_reg, act_next, want_reg, want_next;
	logic       pend_reg, pend_next, rdy_next, en_next;
	logic       rdy_reg, en_reg;
	logic [7:0] wait_reg;

	// Switch ratio only at the end of a divided period, so no runt pulses appear.
	always_comb begin
		cnt_next = cnt_reg;
		act_next = act_reg;
		want_next = dv.div_write ? dv.div_code : want_reg;
		pend_next = pend_reg | dv.div_write;
		rdy_next = rdy_reg & ~dv.div_write;
		en_next = 1'b0;
		if (dv.src_tick) begin
			if (cnt_reg >= 7'((DIV_MAX - 1) >> (7 - act_reg))) begin
				cnt_next = 7'h00;
				en_next = 1'b1;
				if (pend_reg && !dv.div_write) begin
					act_next = want_reg;
					pend_next = 1'b0;
					rdy_next = 1'b1;
				end
			end else begin
				cnt_next = cnt_reg + 7'h01;
			end
		end
	end

	// Divider registers; reset leaves a pending apply so ready rises at the first boundary.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_reg <= 7'h00;
			act_reg <= DIV_RST;
			want_reg <= DIV_RST;
			pend_reg <= 1'b1;
			rdy_reg <= 1'b0;
			en_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			act_reg <= act_next;
			want_reg <= want_next;
			pend_reg <= pend_next;
			rdy_reg <= rdy_next;
			en_reg <= en_next;
		end
	end

	assign dv.ready = rdy_reg;
	assign dv.core_en = en_reg;

	// Source ticks spent waiting for a divide change; only the checks read it.
	always_ff @(posedge clk_sys) begin
		if (rst || !pend_reg) wait_reg <= 8'h00;
		else if (dv.src_tick && wait_reg != 8'hff) wait_reg <= wait_reg + 8'h01;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_ready_clear_wr: assert property (dv.div_write |=> !dv.ready)
		else $error("Ready stayed high after a divide write.");
	a_apply_bound: assert property (wait_reg <= 8'(DIV_MAX + 1))
		else $error("Divide change took longer than 128 source cycles.");
	a_ratio_held: assert property (en_reg && !pend_reg |->
		cnt_reg == 7'h00 && rdy_reg)
		else $error("Divided clock edge without ready and reset count.");
endmodule

//--- design/scsd_clock_ctl.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
// Overview of operation
// - Bit 7 of the clock select register is a read-only flag that is 1 once the divide is applied.
// - The selected source is divided by 1 to 128 in powers of two from the field at bits 6:4.
// - Bit 3 of the clock select register reads zero and software writes only zero there.
// - Bits 2:0 pick the internal oscillator on 000 and the external one on 001.
// - After reset the internal oscillator is the system clock source.
// - The internal oscillator passes a prescaler of 1, 2, 4 or 8 that resets to divide by 8.
// - With spread enabled the internal oscillator follows a triangle at its frequency over 384.
// - Spread steps change every 32 oscillator cycles by 0.25% within plus or minus 0.75%.
// - The trim field at bits 6:0 sets the period monotonically, zero being fastest.
// - Reset loads the trim with the calibration value that gives 24.5 MHz.
// - A divide change completes within 128 undivided source cycles and then sets ready.
// - A source switch takes effect within one period of the slower oscillator.
// - Prescale codes 00, 01 and 10 select divide by 8, 4 and 2.
module scsd_clock_ctl
	import scsd_pkg::*;
#(
	parameter logic [6:0] TRIM_FACTORY = 7'h40 // Per-part calibration; neutral default.
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              ext_osc_tick,
	output logic                   core_clock,
	output logic [2:0]             source_active,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	scsd_div_if dv ();

	// Bus handshake state.
	logic              awr_reg, awr_next;
	logic              wr_reg, wr_next;
	logic              bv_reg, bv_next;
	logic [1:0]        br_reg, br_next;
	logic              awf_reg, awf_next;
	logic              wf_reg, wf_next;
	logic [ADDR_W-1:0] awa_reg, awa_next;
	logic [7:0]        wd_reg, wd_next;
	logic              ws_reg, ws_next;
	logic              arr_reg, arr_next;
	logic              rv_reg, rv_next;
	logic [1:0]        rr_reg, rr_next;
	logic [7:0]        rd_reg, rd_next;
	logic              do_wr;

	// Register contents.
	logic [2:0]        sel_reg, sel_next;
	logic [2:0]        div_reg, div_next;
	logic [6:0]        trim_reg, trim_next;
	logic              sse_reg, sse_next;
	logic [1:0]        pre_reg, pre_next;
	logic              dw_reg, dw_next;

	// Source switch state.
	scsd_sw_t          sw_reg, sw_next;
	logic [2:0]        act_reg, act_next;
	logic              seen_i_reg, seen_i_next;
	logic              seen_e_reg, seen_e_next;
	logic              tick_reg, tick_next;
	logic              int_tick;
	logic              core_reg;

	// Address decode shared by the read and the write path.
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a[ADDR_W-1:IDX_LSB] == (ADDR_W-IDX_LSB)'(idx) && a[IDX_LSB-1:0] == '0;
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return hit(a, IDX_SRC) || hit(a, IDX_TRIM) || hit(a, IDX_CTRL);
	endfunction

	// Write channel: address and data are latched in either order, then one response.
	always_comb begin
		awr_next = awr_reg;
		wr_next = wr_reg;
		bv_next = bv_reg;
		br_next = br_reg;
		awf_next = awf_reg;
		wf_next = wf_reg;
		awa_next = awa_reg;
		wd_next = wd_reg;
		ws_next = ws_reg;
		do_wr = 1'b0;
		if (s_axi_awvalid && awr_reg) begin
			awf_next = 1'b1;
			awr_next = 1'b0;
			awa_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wr_reg) begin
			wf_next = 1'b1;
			wr_next = 1'b0;
			wd_next = s_axi_wdata[7:0];
			ws_next = s_axi_wstrb[0];
		end
		if (awf_reg && wf_reg && !bv_reg) begin
			do_wr = ws_reg && mapped(awa_reg);
			bv_next = 1'b1;
			br_next = mapped(awa_reg) ? RESP_OK : RESP_ERR;
		end
		if (bv_reg && s_axi_bready) begin
			bv_next = 1'b0;
			awf_next = 1'b0;
			wf_next = 1'b0;
			awr_next = 1'b1;
			wr_next = 1'b1;
		end
	end

	// Write channel registers; both readies open after reset.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			awr_reg <= 1'b1;
			wr_reg <= 1'b1;
			bv_reg <= 1'b0;
			br_reg <= RESP_OK;
			awf_reg <= 1'b0;
			wf_reg <= 1'b0;
			awa_reg <= '0;
			wd_reg <= 8'h00;
			ws_reg <= 1'b0;
		end else begin
			awr_reg <= awr_next;
			wr_reg <= wr_next;
			bv_reg <= bv_next;
			br_reg <= br_next;
			awf_reg <= awf_next;
			wf_reg <= wf_next;
			awa_reg <= awa_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
		end
	end

	// Register writes; reserved source codes are dropped so the mux never sees them.
	always_comb begin
		sel_next = sel_reg;
		div_next = div_reg;
		trim_next = trim_reg;
		sse_next = sse_reg;
		pre_next = pre_reg;
		dw_next = 1'b0;
		if (do_wr && hit(awa_reg, IDX_SRC)) begin
			div_next = wd_reg[DIV_LSB +: 3];
			dw_next = 1'b1;
			if (wd_reg[SEL_LSB +: 3] == SEL_INT || wd_reg[SEL_LSB +: 3] == SEL_EXT) begin
				sel_next = wd_reg[SEL_LSB +: 3];
			end
		end
		if (do_wr && hit(awa_reg, IDX_TRIM)) trim_next = wd_reg[6:0];
		if (do_wr && hit(awa_reg, IDX_CTRL)) begin
			sse_next = wd_reg[SSE_BIT];
			pre_next = wd_reg[PRE_LSB +: 2];
		end
	end

	// Register file; trim takes the calibration value at reset.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sel_reg <= SEL_INT;
			div_reg <= DIV_RST;
			trim_reg <= TRIM_FACTORY;
			sse_reg <= 1'b0;
			pre_reg <= PRE_D8;
			dw_reg <= 1'b0;
		end else begin
			sel_reg <= sel_next;
			div_reg <= div_next;
			trim_reg <= trim_next;
			sse_reg <= sse_next;
			pre_reg <= pre_next;
			dw_reg <= dw_next;
		end
	end

	// Read channel: one read in flight, data is captured when the address is taken.
	always_comb begin
		arr_next = arr_reg;
		rv_next = rv_reg;
		rr_next = rr_reg;
		rd_next = rd_reg;
		if (s_axi_arvalid && arr_reg) begin
			arr_next = 1'b0;
			rv_next = 1'b1;
			rr_next = mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
			rd_next = 8'h00;
			if (hit(s_axi_araddr, IDX_SRC)) begin
				rd_next[RDY_BIT] = dv.ready;
				rd_next[DIV_LSB +: 3] = div_reg;
				rd_next[RSV_BIT] = 1'b0;
				rd_next[SEL_LSB +: 3] = sel_reg;
			end
			if (hit(s_axi_araddr, IDX_TRIM)) rd_next[6:0] = trim_reg;
			if (hit(s_axi_araddr, IDX_CTRL)) begin
				rd_next[SSE_BIT] = sse_reg;
				rd_next[PRE_LSB +: 2] = pre_reg;
			end
		end
		if (rv_reg && s_axi_rready) begin
			rv_next = 1'b0;
			arr_next = 1'b1;
		end
	end

	// Read channel registers.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			arr_reg <= 1'b1;
			rv_reg <= 1'b0;
			rr_reg <= RESP_OK;
			rd_reg <= 8'h00;
		end else begin
			arr_reg <= arr_next;
			rv_reg <= rv_next;
			rr_reg <= rr_next;
			rd_reg <= rd_next;
		end
	end

	assign s_axi_awready = awr_reg;
	assign s_axi_wready = wr_reg;
	assign s_axi_bvalid = bv_reg;
	assign s_axi_bresp = br_reg;
	assign s_axi_arready = arr_reg;
	assign s_axi_rvalid = rv_reg;
	assign s_axi_rresp = rr_reg;
	assign s_axi_rdata = {24'h000000, rd_reg};

	// Internal oscillator with trim, spread modulation and its prescaler.
	scsd_int_osc #(
		.TRIM_W        (7)
	) u_osc (
		.clk_sys       (clk_sys),
		.rst           (rst),
		.trim          (trim_reg),
		.spread_enable (sse_reg),
		.prescale      (pre_reg),
		.pre_tick      (int_tick)
	);

	// A switch waits for one cycle of each oscillator, which ends within the slower one's period.
	always_comb begin
		sw_next = sw_reg;
		act_next = act_reg;
		seen_i_next = seen_i_reg | int_tick;
		seen_e_next = seen_e_reg | ext_osc_tick;
		case (sw_reg)
			SW_RUN: begin
				if (sel_reg != act_reg) begin
					sw_next = SW_WAIT;
					seen_i_next = 1'b0;
					seen_e_next = 1'b0;
				end
			end
			SW_WAIT: begin
				if (seen_i_reg && seen_e_reg) begin
					act_next = sel_reg;
					sw_next = SW_RUN;
				end
			end
			default: begin
				sw_next = SW_RUN;
			end
		endcase
		tick_next = (act_reg == SEL_EXT) ? ext_osc_tick : int_tick;
	end

	// Source switch registers; reset returns to the internal oscillator.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sw_reg <= SW_RUN;
			act_reg <= SEL_INT;
			seen_i_reg <= 1'b0;
			seen_e_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			sw_reg <= sw_next;
			act_reg <= act_next;
			seen_i_reg <= seen_i_next;
			seen_e_reg <= seen_e_next;
			tick_reg <= tick_next;
		end
	end

	assign dv.src_tick = tick_reg;
	assign dv.div_code = div_reg;
	assign dv.div_write = dw_reg;

	// Power-of-two divider producing the core clock enable.
	scsd_sysdiv u_div (
		.clk_sys (clk_sys),
		.rst     (rst),
		.dv      (dv)
	);

	// Core clock enable and active source leave through flops.
	always_ff @(posedge clk_sys) begin
		if (rst) core_reg <= 1'b0;
		else core_reg <= dv.core_en;
	end

	assign core_clock = core_reg;
	assign source_active = act_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_rst_internal: assert property ($fell(rst) |-> act_reg == SEL_INT)
		else $error("Source is not internal after reset.");
	a_rst_prescale: assert property ($fell(rst) |-> pre_reg == PRE_D8)
		else $error("Prescaler did not reset to divide by 8.");
	a_rst_trim: assert property ($fell(rst) |-> trim_reg == TRIM_FACTORY)
		else $error("Trim did not load the calibration value.");
	a_rsvd_reads_zero: assert property (s_axi_arvalid && arr_reg && hit(s_axi_araddr, IDX_SRC) |=>
		!rd_reg[RSV_BIT])
		else $error("Reserved bit read as one.");
	a_ready_readback: assert property (s_axi_arvalid && arr_reg &&
		hit(s_axi_araddr, IDX_SRC) |=> rd_reg[RDY_BIT] == $past(dv.ready))
		else $error("Ready flag readback does not match divider state.");
	a_switch_gated: assert property ($changed(act_reg) |->
		$past(seen_i_reg) && $past(seen_e_reg) && $past(sw_reg) == SW_WAIT)
		else $error("Source switched before both oscillators ticked.");
	a_src_legal: assert property (sel_reg == SEL_INT || sel_reg == SEL_EXT)
		else $error("Reserved source code stored.");
	a_div_write_pulse: assert property (do_wr && hit(awa_reg, IDX_SRC) |=>
		dw_reg ##1 !dv.ready)
		else $error("Divide write did not clear ready.");
endmodule

//--- sim/scsd_clock_ctl_bench.sv
`timescale 1ns/1ps
// Self-checking bench: drives the register bus and the external tick, watches the core clock.
module scsd_clock_ctl_bench;
	import scsd_pkg::*;
	localparam logic [6:0]  TRIM_CAL = 7'h55; // Arbitrary calibration value for this run.
	localparam logic [11:0] A_SEL    = 12'(IDX_SRC) << IDX_LSB;
	localparam logic [11:0] A_TRIM   = 12'(IDX_TRIM) << IDX_LSB;
	localparam logic [11:0] A_CTRL   = 12'(IDX_CTRL) << IDX_LSB;
	logic        clk_sys, rst, core_clock;
	logic        ext_osc_tick = 1'b0;
	logic [2:0]  source_active;
	logic [11:0] awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          failures = 0, n_checks = 0, cyc = 0, ext_cnt = 0, n_rst;

	scsd_clock_ctl #(.TRIM_FACTORY(TRIM_CAL)) u_dut (.clk_sys(clk_sys), .rst(rst),
		.ext_osc_tick(ext_osc_tick), .core_clock(core_clock), .source_active(source_active),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// Clock, cycle count and an external oscillator tick every third cycle.
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		ext_cnt <= (ext_cnt == 2) ? 0 : ext_cnt + 1;
		ext_osc_tick <= (ext_cnt == 2);
	end

	// Comparisons count every check and report a mismatch at once.
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] seen);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic check_rng(input string what, input int lo, input int hi, input int seen);
		n_checks++;
		if (seen < lo || seen > hi) begin
			failures++;
			$display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, seen);
		end
	endtask

	// Bus master: address and data offered together, each released when taken.
	// Response readies stay high, so back-to-back calls never drive them twice in one step.
	task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		bit aw, w;
		aw = 1;
		w = 1;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		wvalid <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (!aw && !w && bvalid === 1'b1) begin
				r = bresp;
				break;
			end
			if (aw && awready === 1'b1) begin
				aw = 0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 0;
				wvalid <= 1'b0;
			end
		end
	endtask
	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ar;
		ar = 1;
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (!ar && rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				break;
			end
			if (ar && arready === 1'b1) begin
				ar = 0;
				arvalid <= 1'b0;
			end
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_write(a, d, r);
		check_val("write response", 32'(RESP_OK), 32'(r));
	endtask
	task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] mask,
		input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(a, d, r);
		check_val("read response", 32'(RESP_OK), 32'(r));
		check_val(what, {24'h0, exp}, d & {24'h0, mask});
	endtask
	// Polls until the divider reports the new setting applied.
	task automatic wait_ready();
		logic [31:0] d;
		logic [1:0]  r;
		do axi_read(A_SEL, d, r); while (d[RDY_BIT] !== 1'b1);
	endtask
	task automatic count_pulses(input int span, output int n);
		n = 0;
		repeat (span) begin
			@(posedge clk_sys);
			if (core_clock === 1'b1) n++;
		end
	endtask
	// Cycles between two core clock pulses, once one pulse has been seen.
	task automatic period(output int p);
		do @(posedge clk_sys); while (core_clock !== 1'b1);
		p = 0;
		do begin
			@(posedge clk_sys);
			p++;
		end while (core_clock !== 1'b1);
	endtask

	task automatic t_reset();
		repeat (20) @(posedge clk_sys);
		rd_chk("select after reset", A_SEL, 8'hff, 8'h80);
		check_val("source after reset", 32'(SEL_INT), 32'(source_active));
		rd_chk("trim after reset", A_TRIM, 8'hff, {1'b0, TRIM_CAL});
		rd_chk("control after reset", A_CTRL, 8'h0b, 8'h00);
		count_pulses(2000, n_rst);
		$display("test reset done");
	endtask
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		wr(A_TRIM, 8'hff);
		rd_chk("trim all ones", A_TRIM, 8'hff, 8'h7f);
		wr(A_TRIM, 8'h00);
		rd_chk("trim zero", A_TRIM, 8'hff, 8'h00);
		axi_write(12'h000, 8'h5a, r);
		check_val("unmapped write response", 32'(RESP_ERR), 32'(r));
		axi_read(12'h000, d, r);
		check_val("unmapped read response", 32'(RESP_ERR), 32'(r));
		check_val("unmapped read data", 32'h0, d);
		wr(A_TRIM, {1'b0, TRIM_CAL});
		$display("test registers done");
	endtask
	task automatic t_source();
		int k;
		wr(A_SEL, 8'h01);
		k = 0;
		while (source_active !== SEL_EXT && k < 60) begin
			@(posedge clk_sys);
			k++;
		end
		check_val("source switched", 32'(SEL_EXT), 32'(source_active));
		wr(A_SEL, 8'h01);
		repeat (60) @(posedge clk_sys);
		check_val("source kept", 32'(SEL_EXT), 32'(source_active));
		rd_chk("source code readback", A_SEL, 8'h7f, 8'h01);
		$display("test source done");
	endtask
	// Walks every divide code downward, syncing each write to a pulse so the old period is long.
	task automatic t_divide();
		int t0, p;
		for (int d = 7; d >= 0; d--) begin
			period(p);
			t0 = cyc;
			wr(A_SEL, 8'(d << DIV_LSB) | 8'h01);
			if (d >= 1 && d <= 6) rd_chk("ready cleared", A_SEL, 8'h80, 8'h00);
			wait_ready();
			check_rng("divide settle cycles", 0, DIV_MAX * 3 + 16, cyc - t0);
			period(p);
			check_val("core period", 32'(3 << d), 32'(p));
		end
		$display("test divide done");
	endtask
	// Expected counts follow the oscillator model's increment at the calibration trim.
	task automatic t_prescale();
		int n1, n;
		int divs[4] = '{1, 2, 4, 8};
		logic [1:0] codes[4] = '{PRE_D1, PRE_D2, PRE_D4, PRE_D8};
		n1 = 2000 * (INC_NOM + (TRIM_MID - int'(TRIM_CAL)) * TRIM_STEP) / (1 << PH_W);
		wr(A_SEL, 8'h00);
		wait_ready();
		for (int i = 0; i < 4; i++) begin
			wr(A_CTRL, {6'h0, codes[i]});
			repeat (50) @(posedge clk_sys);
			count_pulses(2000, n);
			check_rng("prescaled pulses", n1 / divs[i] - 2, n1 / divs[i] + 2, n);
		end
		check_rng("reset prescale pulses", n1 / 8 - 2, n1 / 8 + 2, n_rst);
		$display("test prescale done");
	endtask
	task automatic t_trim_spread();
		int nf, ns, n0, n1;
		wr(A_CTRL, {6'h0, PRE_D1});
		wr(A_TRIM, 8'h00);
		count_pulses(2000, nf);
		wr(A_TRIM, 8'h7f);
		count_pulses(2000, ns);
		check_rng("trim fastest above slowest", ns + 1, 1 << 20, nf);
		wr(A_TRIM, {1'b0, TRIM_CAL});
		count_pulses(3840, n0);
		wr(A_CTRL, 8'(1 << SSE_BIT) | {6'h0, PRE_D1});
		rd_chk("spread enable readback", A_CTRL, 8'h0b, 8'(1 << SSE_BIT) | {6'h0, PRE_D1});
		repeat (50) @(posedge clk_sys);
		count_pulses(3840, n1);
		check_rng("spread mean", n0 - n0 * 75 / 10000 - 2, n0 + n0 * 75 / 10000 + 2, n1);
		$display("test trim and spread done");
	endtask
	task automatic t_mid_reset();
		wr(A_SEL, 8'h31);
		rst <= 1'b1;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (20) @(posedge clk_sys);
		check_val("source after mid reset", 32'(SEL_INT), 32'(source_active));
		rd_chk("select after mid reset", A_SEL, 8'hff, 8'h80);
		rd_chk("control after mid reset", A_CTRL, 8'h0b, 8'h00);
		$display("test mid reset done");
	endtask

	task automatic end_sim();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence; reset is held for five cycles before the first request.
	initial begin
		clk_sys = 0;
		rst = 1;
		{awaddr, araddr, awvalid, wvalid, arvalid, wdata, wstrb} = '0;
		{bready, rready} = 2'b11;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_regs();
		t_source();
		t_divide();
		t_prescale();
		t_trim_spread();
		t_mid_reset();
		end_sim();
	end

	// The tests need about 26000 cycles; a hang is cut off well beyond that.
	initial begin
		repeat (90000) @(posedge clk_sys);
		failures++;
		$display("mismatch watchdog expected finish seen timeout");
		end_sim();
	end
endmodule
